// *** common/ubk_pkg.sv ***
// constants, register map and decode helpers of the user break unit
// assumes one clock, synchronous reset, and a plain register port
package ubk_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int REG_ADDR_W = 28;
    localparam int REG_W = 16;
    localparam int DATA_W = 32;
    localparam int BUS_ADDR_W = 32;
    localparam int SLOT_W = 3;
    localparam int ST_W = 3;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [27:0] OFS_ADDR_HIGH = 28'h5ffff90;
    localparam logic [27:0] OFS_ADDR_LOW = 28'h5ffff92;
    localparam logic [27:0] OFS_MASK_HIGH = 28'h5ffff94;
    localparam logic [27:0] OFS_MASK_LOW = 28'h5ffff96;
    localparam logic [27:0] OFS_CYCLE_SEL = 28'h5ffff98;
    localparam logic [27:0] OFS_IRQ_MASK = 28'h5ffff9a;
    localparam logic [27:0] OFS_IRQ_STATUS = 28'h5ffff9c;

    localparam logic [3:0] AREA_SEL = OFS_ADDR_HIGH[27:24];
    localparam logic [4:0] ROW_SEL = OFS_ADDR_HIGH[8:4];
    localparam logic [2:0] SLOT_ADDR_HIGH = OFS_ADDR_HIGH[3:1];
    localparam logic [2:0] SLOT_ADDR_LOW = OFS_ADDR_LOW[3:1];
    localparam logic [2:0] SLOT_MASK_HIGH = OFS_MASK_HIGH[3:1];
    localparam logic [2:0] SLOT_MASK_LOW = OFS_MASK_LOW[3:1];
    localparam logic [2:0] SLOT_CYCLE = OFS_CYCLE_SEL[3:1];
    localparam logic [2:0] SLOT_IRQ_MASK = OFS_IRQ_MASK[3:1];
    localparam logic [2:0] SLOT_STATUS = OFS_IRQ_STATUS[3:1];
    localparam logic [2:0] NUM_RW = 3'h6;

    localparam logic [15:0] RESET_VAL = 16'h0000;
    localparam logic [15:0] CYCLE_WR_MASK = 16'h00ff;
    localparam logic [15:0] IRQ_MASK_BITS = 16'h0007;

    // ----------------------------------------------------------------
    // cycle select fields
    // ----------------------------------------------------------------
    localparam int CD_DMA_BIT = 7;
    localparam int CD_CPU_BIT = 6;
    localparam int ID_DATA_BIT = 5;
    localparam int ID_FETCH_BIT = 4;
    localparam int RW_WRITE_BIT = 3;
    localparam int RW_READ_BIT = 2;
    localparam int SZ_HI = 1;
    localparam int SZ_LO = 0;

    // width codes, shared by size field, bus cycles and register port
    localparam logic [1:0] SZ_ANY = 2'h0;
    localparam logic [1:0] SZ_BYTE = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;
    localparam logic [1:0] SZ_LONG = 2'h3;

    // status bits
    localparam int ST_FETCH = 0;
    localparam int ST_DATA = 1;
    localparam int ST_DMA = 2;

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    // only bits 27..24 and 8..0 take part; 23..9 alias
    function automatic logic reg_hit(input logic [27:0] a);
        reg_hit = (a[27:24] == AREA_SEL) && (a[8:4] == ROW_SEL)
            && (a[3:1] <= SLOT_STATUS);
    endfunction : reg_hit

    function automatic logic [2:0] reg_slot(input logic [27:0] a);
        reg_slot = a[3:1];
    endfunction : reg_slot

endpackage : ubk_pkg

// *** logic/ubk_match.sv ***
// break condition comparator, purely combinational
// assumes bus cycle signals are stable while cyc_valid is high
`timescale 1ns/10ps
module ubk_match (
    input wire logic [15:0] addr_high,
    input wire logic [15:0] addr_low,
    input wire logic [15:0] mask_high,
    input wire logic [15:0] mask_low,
    input wire logic [15:0] cycle_sel,
    input wire logic [31:0] cyc_addr,
    input wire logic cyc_dma,
    input wire logic cyc_fetch,
    input wire logic cyc_write,
    input wire logic [1:0] cyc_size,
    output logic hit
);
    logic [31:0] cmp_addr;
    logic [31:0] cmp_mask;
    logic [1:0] sz;
    logic addr_ok;
    logic cd_ok;
    logic id_ok;
    logic rw_ok;
    logic sz_ok;

    always_comb begin
        cmp_addr = {addr_high, addr_low};
        cmp_mask = {mask_high, mask_low};
        sz = cycle_sel[ubk_pkg::SZ_HI:ubk_pkg::SZ_LO];
        addr_ok = ((cyc_addr ^ cmp_addr) & ~cmp_mask) == 32'h0000_0000;
        cd_ok = cyc_dma ? cycle_sel[ubk_pkg::CD_DMA_BIT]
                        : cycle_sel[ubk_pkg::CD_CPU_BIT];
        id_ok = cyc_fetch ? cycle_sel[ubk_pkg::ID_FETCH_BIT]
                          : cycle_sel[ubk_pkg::ID_DATA_BIT];
        rw_ok = cyc_write ? cycle_sel[ubk_pkg::RW_WRITE_BIT]
                          : cycle_sel[ubk_pkg::RW_READ_BIT];
        sz_ok = (sz == ubk_pkg::SZ_ANY) || (sz == cyc_size);
        hit = addr_ok && cd_ok && id_ok && rw_ok && sz_ok;
    end

endmodule : ubk_match

// *** logic/ubk_irq.sv ***
// sticky break status, mask gating and level interrupt
// assumes events are one-cycle strobes on the same clock
`timescale 1ns/10ps
module ubk_irq #(
    parameter int W = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] ev,
    input wire logic [W-1:0] mask,
    input wire logic rd_clear,
    output logic [W-1:0] status,
    output logic irq
);
    logic [W-1:0] next_status;
    logic next_irq;

    always_comb begin
        // set wins over a clear in the same cycle, no event lost
        next_status = (status & ~{W{rd_clear}}) | ev;
        // level request while unmasked bit set
        next_irq = |(next_status & mask);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            status <= '0;
            irq <= 1'b0;
        end else begin
            status <= next_status;
            irq <= next_irq;
        end
    end

endmodule : ubk_irq

// *** logic/ubk_top.sv ***
// user break unit: break condition registers, bus cycle watch,
// interrupt request towards the cpu
// assumes cpu and dma cycle signals come from logic on clk, and that
// the cpu samples brk_before_exec at decode of the fetched instruction
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps
module ubk_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic [27:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [1:0] reg_size,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic cyc_valid,
    input wire logic [31:0] cyc_addr,
    input wire logic cyc_dma,
    input wire logic cyc_fetch,
    input wire logic cyc_write,
    input wire logic [1:0] cyc_size,
    output logic brk_irq,
    output logic brk_hit,
    output logic brk_before_exec
);

    // ----------------------------------------------------------------
    // register decode
    // ----------------------------------------------------------------
    logic [15:0] regs [0:5];
    logic [15:0] next_regs [0:5];
    logic [15:0] view [0:7];
    logic [2:0] slot;
    logic [2:0] slot_nx;
    logic sel;
    logic [31:0] next_rdata;
    logic rd_clear;
    logic [2:0] status;
    logic irq_level;

    always_comb begin
        sel = ubk_pkg::reg_hit(reg_addr);
        slot = ubk_pkg::reg_slot(reg_addr);
        slot_nx = slot + 3'h1;
    end

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    // long access covers this slot and the next; big-endian lanes
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            next_regs[i] = regs[i];
        end
        if (reg_wr && sel) begin
            unique case (reg_size)
                ubk_pkg::SZ_BYTE: begin
                    if (slot < ubk_pkg::NUM_RW) begin
                        if (reg_addr[0]) begin
                            next_regs[slot][7:0] = reg_wdata[7:0];
                        end else begin
                            next_regs[slot][15:8] = reg_wdata[7:0];
                        end
                    end
                end
                ubk_pkg::SZ_WORD: begin
                    if (slot < ubk_pkg::NUM_RW) begin
                        next_regs[slot] = reg_wdata[15:0];
                    end
                end
                ubk_pkg::SZ_LONG: begin
                    if (slot < ubk_pkg::NUM_RW) begin
                        next_regs[slot] = reg_wdata[31:16];
                    end
                    if (slot_nx < ubk_pkg::NUM_RW) begin
                        next_regs[slot_nx] = reg_wdata[15:0];
                    end
                end
                default: begin
                end
            endcase
        end
        next_regs[ubk_pkg::SLOT_CYCLE] =
            next_regs[ubk_pkg::SLOT_CYCLE] & ubk_pkg::CYCLE_WR_MASK;
        next_regs[ubk_pkg::SLOT_IRQ_MASK] =
            next_regs[ubk_pkg::SLOT_IRQ_MASK] & ubk_pkg::IRQ_MASK_BITS;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 6; i++) begin
                regs[i] <= ubk_pkg::RESET_VAL;
            end
        end else begin
            for (int i = 0; i < 6; i++) begin
                regs[i] <= next_regs[i];
            end
        end
    end

    // ----------------------------------------------------------------
    // register reads
    // ----------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            view[i] = regs[i];
        end
        view[ubk_pkg::SLOT_STATUS] = {13'h0000, status};
        view[7] = 16'h0000;
        next_rdata = 32'h0000_0000;
        if (reg_rd && sel) begin
            unique case (reg_size)
                ubk_pkg::SZ_BYTE: begin
                    if (reg_addr[0]) begin
                        next_rdata = {24'h00_0000, view[slot][7:0]};
                    end else begin
                        next_rdata = {24'h00_0000, view[slot][15:8]};
                    end
                end
                ubk_pkg::SZ_WORD: begin
                    next_rdata = {16'h0000, view[slot]};
                end
                ubk_pkg::SZ_LONG: begin
                    next_rdata = {view[slot], view[slot_nx]};
                end
                default: begin
                end
            endcase
        end
        // any read that covers the status word clears it
        rd_clear = reg_rd && sel && ((slot == ubk_pkg::SLOT_STATUS)
            || ((reg_size == ubk_pkg::SZ_LONG)
                && (slot_nx == ubk_pkg::SLOT_STATUS)));
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // bus cycle watch
    // ----------------------------------------------------------------
    logic cond_hit;
    logic [2:0] ev;
    logic next_hit;
    logic next_before_exec;

    ubk_match u_match (
        .addr_high(regs[ubk_pkg::SLOT_ADDR_HIGH]),
        .addr_low(regs[ubk_pkg::SLOT_ADDR_LOW]),
        .mask_high(regs[ubk_pkg::SLOT_MASK_HIGH]),
        .mask_low(regs[ubk_pkg::SLOT_MASK_LOW]),
        .cycle_sel(regs[ubk_pkg::SLOT_CYCLE]),
        .cyc_addr(cyc_addr),
        .cyc_dma(cyc_dma),
        .cyc_fetch(cyc_fetch),
        .cyc_write(cyc_write),
        .cyc_size(cyc_size),
        .hit(cond_hit)
    );

    always_comb begin
        ev = 3'h0;
        if (cyc_valid && cond_hit) begin
            if (cyc_dma) begin
                ev[ubk_pkg::ST_DMA] = 1'b1;
            end else if (cyc_fetch) begin
                ev[ubk_pkg::ST_FETCH] = 1'b1;
            end else begin
                ev[ubk_pkg::ST_DATA] = 1'b1;
            end
        end
        next_hit = |ev;
        // flag fetch break ahead of execution
        next_before_exec = ev[ubk_pkg::ST_FETCH];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            brk_hit <= 1'b0;
            brk_before_exec <= 1'b0;
        end else begin
            brk_hit <= next_hit;
            brk_before_exec <= next_before_exec;
        end
    end

    // ----------------------------------------------------------------
    // interrupt
    // ----------------------------------------------------------------
    // sticky event drives interrupt request
    ubk_irq #(
        .W(ubk_pkg::ST_W)
    ) u_irq (
        .clk(clk),
        .rst(rst),
        .ev(ev),
        .mask(regs[ubk_pkg::SLOT_IRQ_MASK][2:0]),
        .rd_clear(rd_clear),
        .status(status),
        .irq(irq_level)
    );

    always_comb begin
        brk_irq = irq_level;
    end

endmodule : ubk_top

// *** sim/ubk_bus_model.sv ***
// cpu and dma bus cycle source facing the user break unit
// assumes one caller of issue() at a time, on the unit's clock
`timescale 1ns/10ps
module ubk_bus_model (
    input wire logic clk,
    output logic cyc_valid,
    output logic [31:0] cyc_addr,
    output logic cyc_dma,
    output logic cyc_fetch,
    output logic cyc_write,
    output logic [1:0] cyc_size
);
    // ----------------------------------------------------------------
    // cycle driver
    // ----------------------------------------------------------------
    initial begin
        {cyc_addr, cyc_dma, cyc_fetch, cyc_write, cyc_size} = '1;
        cyc_valid = 1'h0;
    end

    // one bus cycle of one clock per call, changed just after the edge
    task automatic issue(input logic [31:0] a, input logic d,
        input logic f, input logic w, input logic [1:0] sz);
        @(posedge clk);
        cyc_valid <= 1'h1;
        {cyc_addr, cyc_dma, cyc_fetch, cyc_write, cyc_size} <=
            {a, d, f, w, sz};
        @(posedge clk);
        cyc_valid <= 1'h0;
        // released bus shows the inverse so a stale match cannot hide
        {cyc_addr, cyc_dma, cyc_fetch, cyc_write, cyc_size} <=
            ~{a, d, f, w, sz};
    endtask : issue
endmodule : ubk_bus_model

// *** sim/ubk_top_chk.sv ***
// port-level checks of the user break unit
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
module ubk_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic cyc_valid,
    input wire logic cyc_dma,
    input wire logic cyc_fetch,
    input wire logic brk_irq,
    input wire logic brk_hit,
    input wire logic brk_before_exec
);
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_RESET_QUIET: assert property (
        $past(rst) |-> !brk_irq && !brk_hit && reg_rdata == 32'h0)
        else $error("outputs not quiet after reset");
    AST_RDATA_CAUSE: assert property (
        reg_rdata != 32'h0 |-> $past(reg_rd))
        else $error("read data without a read");
    AST_HIT_CAUSE: assert property (
        brk_hit |-> $past(cyc_valid))
        else $error("break without a bus cycle");
    AST_IDLE_NO_HIT: assert property (
        !cyc_valid |=> !brk_hit)
        else $error("break after an idle clock");
    AST_EXEC_CAUSE: assert property (
        brk_before_exec |-> brk_hit && $past(cyc_fetch && !cyc_dma))
        else $error("early break not from a cpu fetch");
    AST_FETCH_EXEC: assert property (
        cyc_valid && cyc_fetch && !cyc_dma ##1 brk_hit |-> brk_before_exec)
        else $error("cpu fetch break without early break");
    AST_DMA_NO_EXEC: assert property (
        cyc_valid && cyc_dma |=> !brk_before_exec)
        else $error("early break on a dma cycle");
    AST_DATA_NO_EXEC: assert property (
        cyc_valid && !cyc_fetch |=> !brk_before_exec)
        else $error("early break on a data access");
    AST_IRQ_RISE: assert property (
        $rose(brk_irq) |-> brk_hit || $past(reg_wr) || $past(reg_wr, 2))
        else $error("interrupt rose without a cause");
    AST_IRQ_FALL: assert property (
        $fell(brk_irq) |-> $past(reg_rd || reg_wr)
            || $past(reg_rd || reg_wr, 2))
        else $error("interrupt dropped without a clear");
    cover property (brk_hit && brk_before_exec);
    cover property (brk_hit && $past(cyc_dma));
    cover property ($fell(brk_irq));
endmodule : ubk_chk

bind ubk_top ubk_chk u_chk (.clk(clk), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cyc_valid(cyc_valid),
    .cyc_dma(cyc_dma), .cyc_fetch(cyc_fetch), .brk_irq(brk_irq),
    .brk_hit(brk_hit), .brk_before_exec(brk_before_exec));

// *** sim/test_user_break_controller.sv ***
// self-checking bench of the user break unit
// assumes the bus model drives every bus cycle input
`timescale 1ns/10ps
module test_user_break_controller;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic [27:0] reg_addr = 28'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [1:0] reg_size = 2'h0;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [31:0] reg_rdata, cyc_addr;
    logic cyc_valid, cyc_dma, cyc_fetch, cyc_write;
    logic [1:0] cyc_size;
    logic brk_irq, brk_hit, brk_before_exec;
    logic [2:0] exp_st = 3'h0;
    int miscompares = 0;
    int checks_done = 0;

    always #2.5 clk = ~clk;

    ubk_top DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_size(reg_size), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cyc_valid(cyc_valid),
        .cyc_addr(cyc_addr), .cyc_dma(cyc_dma), .cyc_fetch(cyc_fetch),
        .cyc_write(cyc_write), .cyc_size(cyc_size), .brk_irq(brk_irq),
        .brk_hit(brk_hit), .brk_before_exec(brk_before_exec));
    ubk_bus_model bus (.clk(clk), .cyc_valid(cyc_valid),
        .cyc_addr(cyc_addr), .cyc_dma(cyc_dma), .cyc_fetch(cyc_fetch),
        .cyc_write(cyc_write), .cyc_size(cyc_size));

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize

    task automatic cmp(input string n, input logic [31:0] e,
        input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : cmp

    task automatic wr(input logic [27:0] a, input logic [15:0] d,
        input logic [1:0] sz, input logic [15:0] d_lo = 16'h0000);
        @(posedge clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= (sz == 2'h3) ? {d, d_lo} : {16'h0, d};
        reg_size <= sz;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask : wr

    task automatic rdc(input string n, input logic [27:0] a,
        input logic [31:0] e, input logic [1:0] sz = 2'h2);
        @(posedge clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        reg_size <= sz;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1 cmp(n, e, reg_rdata);
    endtask : rdc

    // early break only for a cpu fetch
    task automatic brk(input logic [7:0] sel, input logic [31:0] a,
        input logic d, input logic f, input logic w, input logic [1:0] sz,
        input logic h);
        wr(28'h5ffff98, {8'h0, sel}, 2'h2);
        bus.issue(a, d, f, w, sz);
        #1 cmp("hit", {31'h0, h}, {31'h0, brk_hit});
        cmp("exec", {31'h0, h & f & !d}, {31'h0, brk_before_exec});
        if (h)
            exp_st[d ? 2 : (f ? 0 : 1)] = 1'h1;
    endtask : brk

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        for (int i = 0; i < 5; i++)
            rdc("reset", 28'h5ffff90 + 28'(2 * i), 32'h0);
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            wr(28'h5000190 + 28'(2 * i), 16'ha5c3 + 16'(i), 2'h2);
            rdc("rw", 28'h5ffff90 + 28'(2 * i), 32'ha5c3 + 32'(i));
        end
        wr(28'h5ffff98, 16'hffff, 2'h2);
        rdc("cycle", 28'h5ffff98, 32'h00ff);
        wr(28'h4ffff90, 16'h1111, 2'h2);
        rdc("unmapped", 28'h4ffff90, 32'h0);
        rdc("no alias", 28'h5ffff90, 32'ha5c3);
        wr(28'h5ffff93, 16'h0077, 2'h1);
        rdc("byte", 28'h5ffff92, 32'ha577);
        wr(28'h5ffff94, 16'h1357, 2'h3, 16'h9bdf);
        rdc("long", 28'h5ffff94, 32'h1357_9bdf, 2'h3);
        rdc("byte read", 28'h5ffff95, 32'h0057, 2'h1);
        $display("test registers done");
        wr(28'h5ffff90, 16'h0000, 2'h2);
        wr(28'h5ffff92, 16'h1230, 2'h2);
        wr(28'h5ffff94, 16'h0000, 2'h2);
        wr(28'h5ffff96, 16'h000f, 2'h2);
        wr(28'h5ffff9a, 16'h0000, 2'h2);
        brk(8'h54, 32'h1235, 0, 1, 0, 2'h2, 1);
        brk(8'h54, 32'h1245, 0, 1, 0, 2'h2, 0);
        brk(8'ha8, 32'h1230, 1, 0, 1, 2'h3, 1);
        brk(8'ha8, 32'h1230, 0, 0, 1, 2'h3, 0);
        brk(8'hbc, 32'h1230, 1, 1, 0, 2'h1, 1);
        brk(8'h68, 32'h1230, 0, 0, 0, 2'h2, 0);
        brk(8'hfe, 32'h123f, 0, 0, 0, 2'h2, 1);
        brk(8'hfe, 32'h123f, 0, 0, 0, 2'h1, 0);
        brk(8'hfd, 32'h1230, 0, 0, 1, 2'h1, 1);
        brk(8'hff, 32'h1230, 0, 0, 1, 2'h2, 0);
        brk(8'h3c, 32'h1230, 0, 0, 0, 2'h2, 0);
        brk(8'hcc, 32'h1230, 0, 0, 0, 2'h2, 0);
        brk(8'hf0, 32'h1230, 0, 0, 0, 2'h2, 0);
        $display("test break conditions done");
        cmp("masked irq", 32'h0, {31'h0, brk_irq});
        wr(28'h5ffff9a, 16'h0007, 2'h2);
        repeat (2) @(posedge clk);
        #1 cmp("irq", 32'h1, {31'h0, brk_irq});
        rdc("status", 28'h5ffff9c, {29'h0, exp_st});
        cmp("cleared irq", 32'h0, {31'h0, brk_irq});
        rdc("status clear", 28'h5ffff9c, 32'h0);
        $display("test interrupt done");
        @(posedge clk);
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        rdc("reset again", 28'h5ffff92, 32'h0);
        rdc("mask reset", 28'h5ffff96, 32'h0);
        $display("test mid-run reset done");
        summarize();
    end

    initial begin
        repeat (4000) @(posedge clk);
        miscompares++;
        summarize();
    end
endmodule : test_user_break_controller
